// File: hdl/cusse_cfg.svh
`ifndef CUSSE_CFG_SVH
`define CUSSE_CFG_SVH
// Record and palette field positions
`define CUSSE_FB_CHR_HI 26
`define CUSSE_FB_CHR_LO 24
`define CUSSE_FB_L3_HI 23
`define CUSSE_FB_L3_LO 18
`define CUSSE_FB_L2_HI 17
`define CUSSE_FB_L2_LO 12
`define CUSSE_FB_L1_HI 11
`define CUSSE_FB_L1_LO 6
`define CUSSE_FB_L0_HI 5
`define CUSSE_FB_L0_LO 0
`define CUSSE_PAL_KIND_HI 76
`define CUSSE_PAL_KIND_LO 75
`define CUSSE_PAL_END 74
`define CUSSE_PAL_VAL_HI 73
`define CUSSE_PAL_VAL_LO 72
// Mode codes and limits
`define CUSSE_LUMA_MAX 6'h22
`define CUSSE_LUMA_DC 6'h01
`define CUSSE_CHR_MAX 3'h5
`define CUSSE_CHR_RSVD 3'h1
`define CUSSE_CHR_DC 3'h5
`define CUSSE_TR_DEPTH_MAX 2'h2
`define CUSSE_TU_SPLIT64 5'h04
// Records per LCU
`define CUSSE_REC_LCU64 7'h40
`define CUSSE_REC_LCU32 7'h10
`define CUSSE_REC_LCU16 7'h04
// Statistics
`define CUSSE_SSE_SHIFT 4
`define CUSSE_CLASSES 9
`define CUSSE_STAT_BASE 6'h20
`define CUSSE_SUM_MAX 48'hFFFF_FFFF_FFFF
`define CUSSE_CNT_MAX 20'hF_FFFF
`define CUSSE_FIFO_DEPTH 32
`endif

// File: hdl/cusse_pkg.sv
package cusse_pkg;
  typedef enum logic [2:0] {
    PART_2NX2N = 3'h0,
    PART_2NXN = 3'h1,
    PART_NX2N = 3'h2,
    PART_NXN = 3'h3,
    PART_2NXNU = 3'h4,
    PART_2NXND = 3'h5,
    PART_NLX2N = 3'h6,
    PART_NRX2N = 3'h7
  } cusse_shape_e;
  typedef enum logic [1:0] {
    PAL_REUSE = 2'h0,
    PAL_NEWCOL = 2'h1,
    PAL_INDEX = 2'h2,
    PAL_ESCAPE = 2'h3
  } cusse_palkind_e;
  typedef enum logic [1:0] {
    CODE_PRIMARY = 2'h0,
    CODE_FALLBACK = 2'h1,
    CODE_DC = 2'h2
  } cusse_codesrc_e;
  // Sizes: cuLog2m3 0..3 = 8..64, tuLog2m2 0..4 = 4..64
  typedef struct packed {
    logic intra;
    logic [1:0] cuLog2m3;
    cusse_shape_e shape;
    logic [2:0] tuLog2m2;
    logic dynTerm;
    logic leftAvail;
    logic topAvail;
    logic [31:0] fallback;
  } cusse_rec_s;
  typedef struct packed {
    logic [1:0] lcuLog2m3;
    logic [1:0] minCuLog2m3;
    logic external_encoder_mode;
    logic vp9;
    logic smallInterSplitDisable;
    logic [1:0] trDepthInter;
    logic [1:0] trDepthIntra;
  } cusse_cfg_s;
  typedef struct packed {
    cusse_codesrc_e codeSrc;
    logic [5:0] luma;
    logic [2:0] chroma;
    logic [4:0] tuCount;
    logic tuSplit;
    logic shapeErr;
    logic modeErr;
    logic tuErr;
    logic cfgErr;
    logic lcuDone;
    logic [2:0] hierDepth;
    logic [1:0] lineHalves;
  } cusse_dec_s;
  typedef logic [76:0] cusse_pal_t;
endpackage

// File: hdl/cusse_link_if.sv
interface cusse_link_if;
  import cusse_pkg::*;
  cusse_cfg_s cfg;
  logic recValid;
  logic recReady;
  cusse_rec_s rec;
  logic palValid;
  logic palReady;
  cusse_pal_t palWord;
  logic palCuStart;
  logic [1:0] palCuLog2m3;
  logic frameStart;
  logic sseValid;
  logic [1:0] ssePlane;
  logic [3:0] sseClass;
  logic [23:0] sseVal;
  modport dev (input cfg, recValid, rec, palValid, palWord, palCuStart, palCuLog2m3,
    frameStart, sseValid, ssePlane, sseClass, sseVal, output recReady, palReady);
  modport src (output cfg, recValid, rec, palValid, palWord, palCuStart, palCuLog2m3,
    frameStart, sseValid, ssePlane, sseClass, sseVal, input recReady, palReady);
endinterface

// File: hdl/cusse_dev.sv
`include "cusse_cfg.svh"

module cusse_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `CUSSE_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cusse_fifo_s;
  cusse_fifo_s s_q;
  cusse_fifo_s s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign inReady = s_q.cnt != (AW + 1)'(DEPTH);
  assign outValid = s_q.cnt != '0;
  assign outData = mem[s_q.rp];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
    end
    if (pop)
    begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
    end
    s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[s_q.wp] <= inData;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module cusse_dev (
  input wire logic clk,
  input wire logic arst_n,
  cusse_link_if.dev lnk,
  output cusse_pkg::cusse_dec_s dec,
  output logic decValid,
  input wire logic decReady,
  input wire logic [2:0][15:0] zoneThr,
  input wire logic [5:0] statAddr,
  output logic [31:0] statData,
  output logic palErr
);
  import cusse_pkg::*;
  localparam int CW = 20;
  typedef struct packed {
    logic decValid;
    cusse_dec_s dec;
    logic [6:0] recCnt;
    logic [3:0] endSeen;
    logic [10:0] escCnt;
    logic palErr;
    logic [2:0][47:0] sum;
    logic [`CUSSE_CLASSES-1:0][2:0][CW-1:0] cnt;
    logic [`CUSSE_CLASSES-1:0][CW-1:0] mx;
    logic [31:0] statData;
  } cusse_dev_s;
  cusse_dev_s s_q;
  cusse_dev_s s_d;
  logic fOutValid;
  logic fOutReady;
  logic [$bits(cusse_rec_s)-1:0] fOutData;
  cusse_rec_s r;
  logic [2:0] cuL;
  logic [2:0] trD;
  logic atMin;
  logic [6:0] recLimit;
  logic [19:0] sh;
  logic [48:0] sumNext;
  cusse_palkind_e kind;
  logic [1:0] pv;
  logic [10:0] escNext;
  logic [10:0] escLimit;
  logic [5:0] idx;
  logic [3:0] cls;

  cusse_fifo #(.WIDTH($bits(cusse_rec_s)), .DEPTH(`CUSSE_FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .inValid(lnk.recValid),
    .inReady(lnk.recReady),
    .inData(lnk.rec),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData)
  );

  assign fOutReady = !s_q.decValid || decReady;
  assign lnk.palReady = 1'b1;
  assign dec = s_q.dec;
  assign decValid = s_q.decValid;
  assign statData = s_q.statData;
  assign palErr = s_q.palErr;

  always_comb
  begin
    s_d = s_q;
    r = cusse_rec_s'(fOutData);
    cuL = {1'b0, r.cuLog2m3} + 3'h1;
    trD = cuL - r.tuLog2m2;
    atMin = r.cuLog2m3 == lnk.cfg.minCuLog2m3;
    recLimit = (lnk.cfg.lcuLog2m3 == 2'h3) ? `CUSSE_REC_LCU64 :
      (lnk.cfg.lcuLog2m3 == 2'h2) ? `CUSSE_REC_LCU32 : `CUSSE_REC_LCU16;
    sh = lnk.sseVal[23:`CUSSE_SSE_SHIFT];
    sumNext = {1'b0, s_q.sum[lnk.ssePlane]} + {25'h0, lnk.sseVal};
    kind = cusse_palkind_e'(lnk.palWord[`CUSSE_PAL_KIND_HI:`CUSSE_PAL_KIND_LO]);
    pv = lnk.palWord[`CUSSE_PAL_VAL_HI:`CUSSE_PAL_VAL_LO];
    escNext = s_q.escCnt + {9'h0, pv[1]} + {10'h0, pv[0]};
    escLimit = 11'h010 << {lnk.palCuLog2m3, 1'b0};
    idx = statAddr - `CUSSE_STAT_BASE;
    cls = 4'((idx - 6'h06) >> 1);
    if (decReady)
    begin
      s_d.decValid = 1'b0;
    end
    // Record checks and decisions
    if (fOutValid && fOutReady)
    begin
      s_d.decValid = 1'b1;
      s_d.dec = '0;
      s_d.dec.cfgErr = lnk.cfg.lcuLog2m3 == 2'h0
        || lnk.cfg.minCuLog2m3 > lnk.cfg.lcuLog2m3;
      s_d.dec.hierDepth = {1'b0, lnk.cfg.lcuLog2m3 - lnk.cfg.minCuLog2m3} + 3'h1;
      s_d.dec.lineHalves = lnk.cfg.external_encoder_mode ? 2'h2 : 2'h1;
      if (r.cuLog2m3 > lnk.cfg.lcuLog2m3 || r.cuLog2m3 < lnk.cfg.minCuLog2m3)
      begin
        s_d.dec.shapeErr = 1'b1;
      end
      if (r.shape == PART_NXN && !atMin)
      begin
        s_d.dec.shapeErr = 1'b1;
      end
      if (r.intra && r.shape != PART_2NX2N && r.shape != PART_NXN)
      begin
        s_d.dec.shapeErr = 1'b1;
      end
      if (!r.intra && r.shape[2] && atMin)
      begin
        s_d.dec.shapeErr = 1'b1;
      end
      if (!r.intra && r.cuLog2m3 == 2'h0 && (r.shape == PART_NXN || r.shape[2]))
      begin
        s_d.dec.shapeErr = 1'b1;
      end
      if (r.intra)
      begin
        if (r.fallback[`CUSSE_FB_CHR_HI:`CUSSE_FB_CHR_LO] == `CUSSE_CHR_RSVD
          || r.fallback[`CUSSE_FB_CHR_HI:`CUSSE_FB_CHR_LO] > `CUSSE_CHR_MAX)
        begin
          s_d.dec.modeErr = 1'b1;
        end
        if (r.fallback[`CUSSE_FB_L0_HI:`CUSSE_FB_L0_LO] > `CUSSE_LUMA_MAX)
        begin
          s_d.dec.modeErr = 1'b1;
        end
        if (r.shape == PART_NXN && (r.fallback[`CUSSE_FB_L1_HI:`CUSSE_FB_L1_LO] > `CUSSE_LUMA_MAX
          || r.fallback[`CUSSE_FB_L2_HI:`CUSSE_FB_L2_LO] > `CUSSE_LUMA_MAX
          || r.fallback[`CUSSE_FB_L3_HI:`CUSSE_FB_L3_LO] > `CUSSE_LUMA_MAX))
        begin
          s_d.dec.modeErr = 1'b1;
        end
      end
      if (r.dynTerm && !r.leftAvail && !r.topAvail)
      begin
        s_d.dec.codeSrc = CODE_DC;
        s_d.dec.luma = `CUSSE_LUMA_DC;
        s_d.dec.chroma = `CUSSE_CHR_DC;
      end
      else if (r.dynTerm && (r.leftAvail ^ r.topAvail))
      begin
        s_d.dec.codeSrc = CODE_FALLBACK;
        s_d.dec.luma = r.fallback[`CUSSE_FB_L0_HI:`CUSSE_FB_L0_LO];
        s_d.dec.chroma = r.fallback[`CUSSE_FB_CHR_HI:`CUSSE_FB_CHR_LO];
      end
      // Transform unit count by depth
      if (r.cuLog2m3 == 2'h3 && r.tuLog2m2 == 3'h4)
      begin
        s_d.dec.tuCount = `CUSSE_TU_SPLIT64;
        s_d.dec.tuSplit = 1'b1;
      end
      else if (r.tuLog2m2 > cuL || trD > 3'h2)
      begin
        s_d.dec.tuErr = 1'b1;
      end
      else
      begin
        s_d.dec.tuCount = 5'h01 << {trD[1:0], 1'b0};
      end
      if (s_q.recCnt == recLimit - 7'h01)
      begin
        s_d.recCnt = '0;
        s_d.dec.lcuDone = 1'b1;
      end
      else
      begin
        s_d.recCnt = s_q.recCnt + 7'h01;
      end
    end
    // Palette map checks
    if (lnk.palCuStart)
    begin
      s_d.endSeen = '0;
      s_d.escCnt = '0;
      s_d.palErr = 1'b0;
    end
    if (lnk.palValid)
    begin
      if (s_d.endSeen[kind])
      begin
        s_d.palErr = 1'b1;
      end
      if (lnk.palWord[`CUSSE_PAL_END])
      begin
        s_d.endSeen[kind] = 1'b1;
      end
      if ((kind == PAL_NEWCOL || kind == PAL_ESCAPE) && pv == 2'h2)
      begin
        s_d.palErr = 1'b1;
      end
      if (kind == PAL_ESCAPE)
      begin
        s_d.escCnt = escNext;
        if (escNext > escLimit)
        begin
          s_d.palErr = 1'b1;
        end
      end
    end
    // Frame SSE statistics, kept for either codec
    if (lnk.frameStart)
    begin
      s_d.sum = '0;
      s_d.cnt = '0;
      s_d.mx = '0;
    end
    else if (lnk.sseValid)
    begin
      if (lnk.ssePlane != 2'h3)
      begin
        s_d.sum[lnk.ssePlane] = sumNext[48] ? `CUSSE_SUM_MAX : sumNext[47:0];
      end
      if (lnk.sseClass < 4'(`CUSSE_CLASSES))
      begin
        for (int z = 0; z < 3; z++)
        begin
          if (sh >= {4'h0, zoneThr[z]} && s_q.cnt[lnk.sseClass][z] != `CUSSE_CNT_MAX)
          begin
            s_d.cnt[lnk.sseClass][z] = s_q.cnt[lnk.sseClass][z] + 20'h1;
          end
        end
        if (sh > s_q.mx[lnk.sseClass])
        begin
          s_d.mx[lnk.sseClass] = sh;
        end
      end
    end
    // Statistics read port
    s_d.statData = '0;
    if (statAddr >= `CUSSE_STAT_BASE && idx < 6'h06)
    begin
      s_d.statData = idx[0] ? {16'h0, s_q.sum[idx[2:1]][47:32]}
        : s_q.sum[idx[2:1]][31:0];
    end
    else if (statAddr >= `CUSSE_STAT_BASE && cls < 4'(`CUSSE_CLASSES))
    begin
      s_d.statData = idx[0] ? {(s_q.mx[cls][19:16] != 4'h0) ? 16'hFFFF : s_q.mx[cls][15:0],
        s_q.cnt[cls][2][19:4]} : {s_q.cnt[cls][1][19:4], s_q.cnt[cls][0][19:4]};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// File: hdl/cusse_src.sv
`include "cusse_cfg.svh"

module cusse_src (
  input wire logic clk,
  input wire logic arst_n,
  cusse_link_if.src lnk,
  input cusse_pkg::cusse_cfg_s cfgIn,
  input wire logic usrRecValid,
  output logic usrRecReady,
  input cusse_pkg::cusse_rec_s usrRec,
  output logic usrReject,
  input wire logic usrPalValid,
  output logic usrPalReady,
  input cusse_pkg::cusse_pal_t usrPalWord,
  input wire logic usrPalCuStart,
  input wire logic [1:0] usrPalCuLog2m3,
  input wire logic usrFrameStart,
  input wire logic usrSseValid,
  input wire logic [1:0] usrSsePlane,
  input wire logic [3:0] usrSseClass,
  input wire logic [23:0] usrSseVal
);
  import cusse_pkg::*;
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_HOLD = 2'b01
  } cusse_srcst_e;
  typedef struct packed {
    cusse_srcst_e st;
    cusse_cfg_s cfg;
    cusse_rec_s rec;
    logic reject;
    logic palValid;
    cusse_pal_t palWord;
    logic palCuStart;
    logic [1:0] palCuLog2m3;
    logic frameStart;
    logic sseValid;
    logic [1:0] ssePlane;
    logic [3:0] sseClass;
    logic [23:0] sseVal;
  } cusse_src_s;
  cusse_src_s s_q;
  cusse_src_s s_d;
  logic illegal;

  assign usrRecReady = s_q.st == SRC_IDLE;
  assign usrPalReady = !s_q.palValid || lnk.palReady;
  assign usrReject = s_q.reject;
  assign lnk.cfg = s_q.cfg;
  assign lnk.recValid = s_q.st == SRC_HOLD;
  assign lnk.rec = s_q.rec;
  assign lnk.palValid = s_q.palValid;
  assign lnk.palWord = s_q.palWord;
  assign lnk.palCuStart = s_q.palCuStart;
  assign lnk.palCuLog2m3 = s_q.palCuLog2m3;
  assign lnk.frameStart = s_q.frameStart;
  assign lnk.sseValid = s_q.sseValid;
  assign lnk.ssePlane = s_q.ssePlane;
  assign lnk.sseClass = s_q.sseClass;
  assign lnk.sseVal = s_q.sseVal;

  always_comb
  begin
    s_d = s_q;
    illegal = (!usrRec.intra && usrRec.cuLog2m3 == 2'h0 && usrRec.shape == PART_NXN
      && cfgIn.smallInterSplitDisable)
      || (usrRec.cuLog2m3 == 2'h3 && usrRec.tuLog2m2 < 3'h2)
      || (usrRec.cuLog2m3 == 2'h2 && usrRec.tuLog2m2 == 3'h0)
      || cfgIn.trDepthInter > `CUSSE_TR_DEPTH_MAX
      || cfgIn.trDepthIntra > `CUSSE_TR_DEPTH_MAX;
    s_d.cfg = cfgIn;
    s_d.reject = 1'b0;
    unique case (s_q.st)
      SRC_IDLE:
      begin
        if (usrRecValid && illegal)
        begin
          s_d.reject = 1'b1;
        end
        else if (usrRecValid)
        begin
          s_d.rec = usrRec;
          s_d.st = SRC_HOLD;
        end
      end
      SRC_HOLD:
      begin
        if (lnk.recReady)
        begin
          s_d.st = SRC_IDLE;
        end
      end
      default:
      begin
        s_d.st = SRC_IDLE;
      end
    endcase
    if (usrPalReady)
    begin
      s_d.palValid = usrPalValid;
      s_d.palWord = usrPalWord;
    end
    s_d.palCuStart = usrPalCuStart;
    s_d.palCuLog2m3 = usrPalCuLog2m3;
    s_d.frameStart = usrFrameStart;
    s_d.sseValid = usrSseValid;
    s_d.ssePlane = usrSsePlane;
    s_d.sseClass = usrSseClass;
    s_d.sseVal = usrSseVal;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule

// File: test/cusse_props.sv
module cusse_props (
  input wire logic clk,
  input wire logic arst_n,
  input cusse_pkg::cusse_cfg_s cfg,
  input wire logic recValid,
  input wire logic recReady,
  input cusse_pkg::cusse_rec_s rec,
  input wire logic palValid,
  input wire logic palReady
);
  timeunit 1ns;
  timeprecision 1ps;
  import cusse_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  sequence recTake;
    recValid && recReady;
  endsequence
  sequence recStall;
    recValid && !recReady;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  hold_valid_a: assert property (recStall |=> recValid)
    else $error("record valid dropped before acceptance");
  hold_data_a: assert property (recStall |=> $stable(rec))
    else $error("record changed while stalled");
  rec_gap_a: assert property (recTake |=> !recValid)
    else $error("records offered back to back");
  small_split_a: assert property (recValid && cfg.smallInterSplitDisable && !rec.intra
    && rec.cuLog2m3 == 2'h0 |-> rec.shape != PART_NXN)
    else $error("small inter split forwarded");
  tu_cu64_a: assert property (recValid && rec.cuLog2m3 == 2'h3 |-> rec.tuLog2m2 > 3'h1)
    else $error("small transform in large unit");
  tu_cu32_a: assert property (recValid && rec.cuLog2m3 == 2'h2 |-> rec.tuLog2m2 != 3'h0)
    else $error("smallest transform in 32 unit");
  tr_depth_a: assert property (recValid |-> cfg.trDepthInter <= 2'h2
    && cfg.trDepthIntra <= 2'h2)
    else $error("record forwarded with deep transform tree");
  pal_accept_a: assert property (palValid |-> palReady)
    else $error("palette word stalled");
endmodule

// File: test/encoder_cu_record_and_sse_stats_bench.sv
module encoder_cu_record_and_sse_stats_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import cusse_pkg::*;
  logic clk, arst_n, usrRecValid, usrRecReady, usrReject, usrPalValid, usrPalReady;
  logic usrPalCuStart, usrFrameStart, usrSseValid, decValid, decReady, palErr, rej;
  cusse_cfg_s cfgIn;
  cusse_rec_s usrRec, r0;
  cusse_pal_t usrPalWord;
  cusse_dec_s dec;
  logic [1:0] usrPalCuLog2m3, usrSsePlane;
  logic [3:0] usrSseClass;
  logic [23:0] usrSseVal;
  logic [2:0][15:0] zoneThr;
  logic [5:0] statAddr;
  logic [31:0] statData;
  logic [4:0] hd;
  int n_errors = 0, check_count = 0, cycles = 0, n, d;
  cusse_link_if cusse_link_if_inst ();
  cusse_src cusse_src_inst (.clk(clk), .arst_n(arst_n), .lnk(cusse_link_if_inst.src),
    .cfgIn(cfgIn), .usrRecValid(usrRecValid), .usrRecReady(usrRecReady), .usrRec(usrRec),
    .usrReject(usrReject), .usrPalValid(usrPalValid), .usrPalReady(usrPalReady),
    .usrPalWord(usrPalWord), .usrPalCuStart(usrPalCuStart), .usrPalCuLog2m3(usrPalCuLog2m3),
    .usrFrameStart(usrFrameStart), .usrSseValid(usrSseValid), .usrSsePlane(usrSsePlane),
    .usrSseClass(usrSseClass), .usrSseVal(usrSseVal));
  cusse_dev cusse_dev_inst (.clk(clk), .arst_n(arst_n), .lnk(cusse_link_if_inst.dev),
    .dec(dec), .decValid(decValid), .decReady(decReady), .zoneThr(zoneThr),
    .statAddr(statAddr), .statData(statData), .palErr(palErr));
  cusse_props cusse_props_inst (.clk(clk), .arst_n(arst_n), .cfg(cusse_link_if_inst.cfg),
    .recValid(cusse_link_if_inst.recValid), .recReady(cusse_link_if_inst.recReady),
    .rec(cusse_link_if_inst.rec), .palValid(cusse_link_if_inst.palValid),
    .palReady(cusse_link_if_inst.palReady));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic cusse_rec_s mk(input logic i, input logic [1:0] cu, input cusse_shape_e sh,
    input logic [2:0] tu, input logic [2:0] nb, input logic [31:0] fb);
    return {i, cu, sh, tu, nb, fb};
  endfunction
  function automatic logic [31:0] ex(input logic [1:0] s, input logic [5:0] l,
    input logic [2:0] c, input logic [4:0] t, input logic [4:0] e);
    return {6'h00, s, l, c, t, e, hd};
  endfunction
  function automatic logic [31:0] got();
    return {6'h00, dec.codeSrc, dec.luma, dec.chroma, dec.tuCount, dec.tuSplit, dec.shapeErr,
      dec.modeErr, dec.tuErr, dec.cfgErr, dec.hierDepth, dec.lineHalves};
  endfunction
  task automatic setCfg(input logic [1:0] l, input logic e, input logic s, input logic [1:0] ti);
    cfgIn = {l, 2'h0, e, 1'b0, s, ti, 2'h2};
    hd = {{1'b0, l} + 3'h1, e ? 2'h2 : 2'h1};
    cyc(2);
  endtask
  task automatic sendRec(input cusse_rec_s r, output logic rj);
    int k;
    k = 0;
    usrRec = r;
    usrRecValid = 1'b1;
    while (usrRecReady !== 1'b1 && k < 200)
    begin
      cyc(1);
      k++;
    end
    cyc(1);
    usrRecValid = 1'b0;
    rj = usrReject;
    cyc(1);
    rj = rj | usrReject;
  endtask
  task automatic legal(input cusse_rec_s r, input logic [31:0] e);
    int k;
    k = 0;
    sendRec(r, rej);
    chk(rej, 1'b0);
    while (decValid !== 1'b1 && k < 100)
    begin
      cyc(1);
      k++;
    end
    chk(got(), e);
    cyc(1);
  endtask
  task automatic illegal(input cusse_rec_s r);
    sendRec(r, rej);
    cyc(2);
    chk({rej, decValid}, 2'b10);
  endtask
  task automatic pal(input logic st, input cusse_palkind_e k, input logic e, input logic [1:0] v);
    usrPalCuStart = st;
    usrPalWord = {k, e, v, 72'h0};
    usrPalValid = 1'b1;
    cyc(1);
    usrPalValid = 1'b0;
    usrPalCuStart = 1'b0;
    cyc(2);
  endtask
  task automatic sse(input logic [1:0] p, input logic [3:0] c, input logic [23:0] v, input int k);
    usrSsePlane = p;
    usrSseClass = c;
    usrSseVal = v;
    usrSseValid = 1'b1;
    cyc(k);
    usrSseValid = 1'b0;
    cyc(1);
  endtask
  task automatic newFrame();
    usrFrameStart = 1'b1;
    cyc(1);
    usrFrameStart = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    statAddr = a;
    cyc(1);
    chk(statData, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    arst_n = 1'b0;
    {usrRecValid, usrPalValid, usrPalCuStart, usrFrameStart, usrSseValid, decReady} = '0;
    usrRec = '0;
    usrPalWord = '0;
    usrPalCuLog2m3 = 2'h0;
    {usrSsePlane, usrSseClass, usrSseVal} = '0;
    zoneThr = {16'h0100, 16'h0020, 16'h0010};
    statAddr = 6'h00;
    setCfg(2'h1, 1'b0, 1'b0, 2'h2);
    arst_n = 1'b1;
    r0 = mk(1'b1, 2'h1, PART_2NX2N, 3'h2, 3'h0, 32'h0);
    repeat (34) sendRec(r0, rej);
    chk(cusse_link_if_inst.recReady, 1'b0);
    chk(got(), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'h00));
    decReady = 1'b1;
    n = 0;
    d = 0;
    repeat (80)
    begin
      if (decValid === 1'b1)
        n++;
      if (decValid === 1'b1 && dec.lcuDone === 1'b1)
        d++;
      cyc(1);
    end
    chk({n, d}, {32'd34, 32'd8});
    legal(mk(1'b1, 2'h1, PART_2NX2N, 3'h2, 3'b100, 32'h0300_000A), ex(2'h2, 6'h01, 3'h5, 5'h01, 5'h00));
    legal(mk(1'b1, 2'h1, PART_2NX2N, 3'h2, 3'b110, 32'h0300_000A), ex(2'h1, 6'h0A, 3'h3, 5'h01, 5'h00));
    legal(mk(1'b1, 2'h1, PART_2NX2N, 3'h2, 3'b101, 32'h0300_000A), ex(2'h1, 6'h0A, 3'h3, 5'h01, 5'h00));
    legal(mk(1'b1, 2'h1, PART_2NX2N, 3'h2, 3'b111, 32'h0300_000A), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'h00));
    for (int c = 0; c < 8; c++)
      legal(mk(1'b1, 2'h1, PART_2NX2N, 3'h2, 3'h0, {5'h0, c[2:0], 24'h0}), ex(2'h0, 6'h00, 3'h0, 5'h01, {2'b00, c == 1 || c > 5, 2'b00}));
    legal(mk(1'b1, 2'h0, PART_NXN, 3'h1, 3'h0, {8'h0, 6'h22, 6'h00, 6'h23, 6'h00}), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'b00100));
    legal(mk(1'b1, 2'h0, PART_NXN, 3'h1, 3'h0, {8'h0, 6'h22, 6'h22, 6'h22, 6'h22}), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'h00));
    legal(mk(1'b1, 2'h1, PART_NXN, 3'h2, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'b01000));
    legal(mk(1'b1, 2'h1, PART_2NXN, 3'h2, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'b01000));
    legal(mk(1'b0, 2'h1, PART_2NXNU, 3'h1, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h04, 5'h00));
    legal(mk(1'b1, 2'h1, PART_2NX2N, 3'h0, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h10, 5'h00));
    for (int s = 0; s < 8; s++)
      legal(mk(1'b0, 2'h0, cusse_shape_e'(s[2:0]), 3'h1, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h01, {1'b0, s > 2, 3'b000}));
    setCfg(2'h0, 1'b0, 1'b0, 2'h2);
    legal(mk(1'b1, 2'h0, PART_2NX2N, 3'h1, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'b00001));
    setCfg(2'h3, 1'b1, 1'b1, 2'h2);
    legal(mk(1'b1, 2'h3, PART_2NX2N, 3'h4, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h04, 5'b10000));
    legal(mk(1'b1, 2'h3, PART_2NX2N, 3'h3, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h04, 5'h00));
    legal(mk(1'b1, 2'h3, PART_2NX2N, 3'h2, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h10, 5'h00));
    legal(mk(1'b1, 2'h2, PART_2NX2N, 3'h3, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'h00));
    legal(mk(1'b0, 2'h0, PART_2NXN, 3'h1, 3'h0, 32'h0), ex(2'h0, 6'h00, 3'h0, 5'h01, 5'h00));
    illegal(mk(1'b1, 2'h3, PART_2NX2N, 3'h1, 3'h0, 32'h0));
    illegal(mk(1'b1, 2'h2, PART_2NX2N, 3'h0, 3'h0, 32'h0));
    illegal(mk(1'b0, 2'h0, PART_NXN, 3'h1, 3'h0, 32'h0));
    setCfg(2'h3, 1'b1, 1'b1, 2'h3);
    illegal(mk(1'b1, 2'h3, PART_2NX2N, 3'h3, 3'h0, 32'h0));
    cfgIn.vp9 = 1'b1;
    newFrame();
    sse(2'h1, 4'h2, 24'h000200, 16);
    sse(2'h0, 4'h2, 24'hFFFFFF, 1);
    cyc(3);
    rd(6'h20, 32'h00FF_FFFF);
    rd(6'h21, 32'h0000_0000);
    rd(6'h22, 32'h0000_2000);
    rd(6'h24, 32'h0000_0000);
    rd(6'h2A, 32'h0001_0001);
    rd(6'h2B, 32'hFFFF_0000);
    rd(6'h26, 32'h0000_0000);
    newFrame();
    rd(6'h20, 32'h0000_0000);
    rd(6'h2A, 32'h0000_0000);
    pal(1'b1, PAL_NEWCOL, 1'b0, 2'h3);
    pal(1'b0, PAL_NEWCOL, 1'b1, 2'h1);
    pal(1'b0, PAL_INDEX, 1'b1, 2'h0);
    pal(1'b0, PAL_REUSE, 1'b1, 2'h0);
    chk(palErr, 1'b0);
    pal(1'b0, PAL_NEWCOL, 1'b0, 2'h1);
    chk(palErr, 1'b1);
    pal(1'b1, PAL_REUSE, 1'b1, 2'h0);
    chk(palErr, 1'b0);
    pal(1'b0, PAL_NEWCOL, 1'b0, 2'h2);
    chk(palErr, 1'b1);
    pal(1'b1, PAL_ESCAPE, 1'b0, 2'h3);
    repeat (7) pal(1'b0, PAL_ESCAPE, 1'b0, 2'h3);
    chk(palErr, 1'b0);
    pal(1'b0, PAL_ESCAPE, 1'b1, 2'h1);
    chk(palErr, 1'b1);
    print_verdict();
  end
endmodule
